/* vcl_pkg.sv */
/*
 vcl_pkg: constants, state types and token helpers shared by both link ends.
 assumes one 10 MHz clk for each end and a four wire serial link between them.
*/
`default_nettype none
package vcl_pkg;
	localparam int CLK_NS = 100;
	localparam int BIT_NS = 800;
	localparam logic [7:0] BIT_CYC = 8'((BIT_NS + CLK_NS - 1) / CLK_NS);
	localparam int NVL = 4;
	localparam logic [5:0] PKT_MAX = 6'h20;
	localparam logic [3:0] DATA_LEN = 4'ha;
	localparam logic [3:0] CTL_LEN = 4'h4;
	localparam logic [1:0] CTL_EOP = 2'h1;
	localparam logic [1:0] CTL_EOM = 2'h2;
	localparam int QDEPTH = 8;
	localparam logic [1:0] RR_RST = 2'h3;

	typedef enum logic [3:0] {
		T_IDLE = 4'h1,
		T_HDR = 4'h2,
		T_BODY = 4'h4,
		T_END = 4'h8
	} vcl_tx_t;

	typedef enum logic [1:0] {
		R_HDR = 2'h1,
		R_BODY = 2'h2
	} vcl_rx_t;

	// odd parity over flag and payload
	function automatic logic tok_par(input logic ctl, input logic [7:0] bits);
		return ctl ? ~^{1'b1, bits[1:0]} : ~^{1'b0, bits};
	endfunction

	// {found, index}; the entry after last wins first
	function automatic logic [2:0] rr_pick(input logic [3:0] req, input logic [1:0] last);
		logic [2:0] r;
		logic [1:0] j;
		r = 3'h0;
		for (int i = NVL; i >= 1; i--) begin
			j = last + 2'(i);
			if (req[j]) r = {1'b1, j};
		end
		return r;
	endfunction
endpackage
`default_nettype wire

/* vcl_link_if.sv */
/*
 vcl_link_if: the four wire serial link between the two ends.
 assumes both ends drive their lines from flops; no wire is shared.
*/
`timescale 1ns/10ps
`default_nettype none
interface vcl_link_if;
	logic dev_data;
	logic dev_strobe;
	logic peer_data;
	logic peer_strobe;
	modport dev (output dev_data, output dev_strobe, input peer_data, input peer_strobe);
	modport peer (input dev_data, input dev_strobe, output peer_data, output peer_strobe);
endinterface
`default_nettype wire

/* vcl_dev_end.sv */
/*
 vcl_fifo, vcl_ds_phy and vcl_dev_end: the multiplexing end of the link.
 assumes per channel byte sources that advance one byte after a take pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module vcl_fifo #(parameter int W = 8, parameter int D = 8) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rp_r];
	assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk) begin
		if (push) mem[wp_r] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop) rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_nxt;
			in_ready <= cnt_nxt != (AW+1)'(D);
		end
	end
endmodule // vcl_fifo

module vcl_ds_phy import vcl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// token to send
	input wire logic tx_valid,
	input wire logic tx_ctl,
	input wire logic [7:0] tx_bits,
	output logic tx_ready,
	// token received
	output logic rx_valid,
	output logic rx_ctl,
	output logic [7:0] rx_bits,
	output logic rx_perr,
	// line
	output logic d_out,
	output logic s_out,
	input wire logic d_in,
	input wire logic s_in
);
	logic [9:0] tsh_r;
	logic [3:0] tcnt_r, rcnt_r;
	logic [7:0] div_r, rpay_r, nbits;
	logic bit_en, d1_r, d2_r, d3_r, s1_r, s2_r, s3_r, rpar_r, rflag_r, edge_seen, last_bit;

	assign bit_en = div_r == BIT_CYC - 8'h1;
	assign tx_ready = tcnt_r == 4'h0;

	always_ff @(posedge clk) begin
		if (sys_rst || bit_en) div_r <= 8'h0;
		else div_r <= div_r + 8'h1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tsh_r <= 10'h0;
			tcnt_r <= 4'h0;
		end else if (tx_valid && tx_ready) begin
			tsh_r <= tx_ctl ? {6'h0, tx_bits[1:0], 1'b1, tok_par(1'b1, tx_bits)} :
				{tx_bits, 1'b0, tok_par(1'b0, tx_bits)};
			tcnt_r <= tx_ctl ? CTL_LEN : DATA_LEN;
		end else if (bit_en && !tx_ready) begin
			tsh_r <= tsh_r >> 1;
			tcnt_r <= tcnt_r - 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			d_out <= 1'b0;
			s_out <= 1'b0;
		end else if (bit_en && !tx_ready) begin
			d_out <= tsh_r[0];
			if (tsh_r[0] == d_out) s_out <= ~s_out;
		end
	end

	// two flops per line before any logic looks at it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{d1_r, d2_r, d3_r, s1_r, s2_r, s3_r} <= 6'h0;
		end else begin
			{d1_r, d2_r, d3_r} <= {d_in, d1_r, d2_r};
			{s1_r, s2_r, s3_r} <= {s_in, s1_r, s2_r};
		end
	end

	assign edge_seen = (d2_r ^ s2_r) != (d3_r ^ s3_r);
	assign last_bit = rcnt_r >= 4'h2 && rcnt_r == (rflag_r ? CTL_LEN : DATA_LEN) - 4'h1;
	assign nbits = rflag_r ? {6'h0, d2_r, rpay_r[7]} : {d2_r, rpay_r[7:1]};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rcnt_r <= 4'h0;
			rpar_r <= 1'b0;
			rflag_r <= 1'b0;
			rpay_r <= 8'h0;
		end else if (edge_seen) begin
			if (rcnt_r == 4'h0) rpar_r <= d2_r;
			else if (rcnt_r == 4'h1) rflag_r <= d2_r;
			else rpay_r <= {d2_r, rpay_r[7:1]};
			rcnt_r <= last_bit ? 4'h0 : rcnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_ctl <= 1'b0;
			rx_bits <= 8'h0;
			rx_perr <= 1'b0;
		end else begin
			rx_valid <= edge_seen && last_bit;
			rx_perr <= edge_seen && last_bit && rpar_r != tok_par(rflag_r, nbits);
			if (edge_seen && last_bit) begin
				rx_ctl <= rflag_r;
				rx_bits <= nbits;
			end
		end
	end
endmodule // vcl_ds_phy

module vcl_dev_end import vcl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link
	vcl_link_if.dev link,
	// send requests: chan[2] marks an on-chip channel
	input wire logic snd_valid,
	input wire logic [2:0] snd_chan,
	output logic snd_ready,
	// per channel byte sources
	input wire logic [3:0] src_valid,
	input wire logic [31:0] src_data,
	input wire logic [3:0] src_last,
	output logic [3:0] src_take,
	// sending processes
	output logic [3:0] out_wait,
	output logic out_done,
	output logic [2:0] out_done_chan,
	// receiving processes
	input wire logic [3:0] in_req,
	output logic [3:0] in_wait,
	output logic rcv_valid,
	output logic [1:0] rcv_chan,
	output logic [7:0] rcv_byte,
	output logic in_done,
	output logic [1:0] in_done_chan,
	output logic link_perr
);
	vcl_tx_t tst_r;
	vcl_rx_t rst_r;
	logic [3:0] fin_r, wack_r, ack_pend_r, bfull_r, beom_r;
	logic [1:0] tvl_r, rr_r, rvl_r, dvl_r;
	logic [5:0] tcnt_r, rcnt_r, didx_r;
	logic [5:0] blen_r [NVL];
	logic [7:0] bmem [NVL * 32];
	logic tack_r, teom_r, rdir_r, dact_r;
	logic ptx_valid, ptx_ctl, ptx_ready, tload, prx_valid, prx_ctl, prx_perr;
	logic [7:0] ptx_bits, prx_bits;
	logic q_valid, q_pop, rx_hdr, rx_byte, rx_end, rx_eom, got_ack, dgo, dfin;
	logic [2:0] q_chan, gnt, dpick, rel;

	vcl_fifo #(.W(3), .D(QDEPTH)) u_sendq (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(snd_valid),
		.in_data(snd_chan),
		.in_ready(snd_ready),
		.out_valid(q_valid),
		.out_data(q_chan),
		.out_ready(q_pop)
	);

	vcl_ds_phy u_phy (
		.clk(clk),
		.sys_rst(sys_rst),
		.tx_valid(ptx_valid),
		.tx_ctl(ptx_ctl),
		.tx_bits(ptx_bits),
		.tx_ready(ptx_ready),
		.rx_valid(prx_valid),
		.rx_ctl(prx_ctl),
		.rx_bits(prx_bits),
		.rx_perr(prx_perr),
		.d_out(link.dev_data),
		.s_out(link.dev_strobe),
		.d_in(link.peer_data),
		.s_in(link.peer_strobe)
	);

	// link events
	assign rx_hdr = prx_valid && !prx_ctl && rst_r == R_HDR;
	assign rx_byte = prx_valid && !prx_ctl && rst_r == R_BODY;
	assign rx_end = prx_valid && prx_ctl && rst_r == R_BODY;
	assign rx_eom = prx_bits[1:0] == CTL_EOM;
	assign got_ack = rx_end && !rx_eom && rcnt_r == 6'h0;
	assign q_pop = q_valid && !rel[2] && (q_chan[2] || !out_wait[q_chan[1:0]]);
	assign gnt = rr_pick(ack_pend_r | (out_wait & ~wack_r & ~fin_r & src_valid), rr_r);
	assign rel = rr_pick(fin_r & ~wack_r, RR_RST);
	assign dpick = rr_pick(in_wait & bfull_r, dvl_r);
	assign dgo = dact_r && !prx_valid;
	assign dfin = dgo && didx_r == blen_r[dvl_r];
	assign tload = ptx_valid && ptx_ready;

	always_comb begin
		ptx_valid = 1'b0;
		ptx_ctl = 1'b0;
		ptx_bits = 8'h0;
		case (tst_r)
			T_HDR: begin
				ptx_valid = 1'b1;
				ptx_bits = {6'h0, tvl_r};
			end
			T_BODY: begin
				ptx_valid = src_valid[tvl_r];
				ptx_bits = src_data[{tvl_r, 3'h0} +: 8];
			end
			T_END: begin
				ptx_valid = 1'b1;
				ptx_ctl = 1'b1;
				ptx_bits = {6'h0, teom_r ? CTL_EOM : CTL_EOP};
			end
			default: ;
		endcase
	end

	// transmit sequencer: one whole packet per grant
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tst_r <= T_IDLE;
			tvl_r <= 2'h0;
			rr_r <= RR_RST;
			tack_r <= 1'b0;
			teom_r <= 1'b0;
			tcnt_r <= 6'h0;
		end else begin
			case (tst_r)
				T_IDLE: if (gnt[2]) begin
					tvl_r <= gnt[1:0];
					rr_r <= gnt[1:0];
					tack_r <= ack_pend_r[gnt[1:0]];
					tst_r <= T_HDR;
				end
				T_HDR: if (tload) begin
					tst_r <= tack_r ? T_END : T_BODY;
					tcnt_r <= 6'h0;
					teom_r <= 1'b0;
				end
				T_BODY: if (tload) begin
					tcnt_r <= tcnt_r + 6'h1;
					if (src_last[tvl_r]) begin
						teom_r <= 1'b1;
						tst_r <= T_END;
					end else if (tcnt_r == PKT_MAX - 6'h1) begin
						tst_r <= T_END;
					end
				end
				T_END: if (tload) tst_r <= T_IDLE;
				default: tst_r <= T_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) src_take <= 4'h0;
		else src_take <= (tst_r == T_BODY && tload) ? 4'h1 << tvl_r : 4'h0;
	end

	// sending channel state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_wait <= 4'h0;
			fin_r <= 4'h0;
			wack_r <= 4'h0;
			out_done <= 1'b0;
			out_done_chan <= 3'h0;
		end else begin
			out_done <= 1'b0;
			if (got_ack) wack_r[rvl_r] <= 1'b0;
			if (tst_r == T_HDR && tload && !tack_r) wack_r[tvl_r] <= 1'b1;
			if (tst_r == T_END && tload && teom_r) fin_r[tvl_r] <= 1'b1;
			if (rel[2]) begin
				out_wait[rel[1:0]] <= 1'b0;
				fin_r[rel[1:0]] <= 1'b0;
				out_done <= 1'b1;
				out_done_chan <= {1'b0, rel[1:0]};
			end
			if (q_pop && q_chan[2]) begin
				out_done <= 1'b1;
				out_done_chan <= q_chan;
			end else if (q_pop) begin
				out_wait[q_chan[1:0]] <= 1'b1;
			end
		end
	end

	// acks owed; a new one wins over the clear by a grant
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_pend_r <= 4'h0;
		end else begin
			if (tst_r == T_IDLE && gnt[2]) ack_pend_r[gnt[1:0]] <= 1'b0;
			if ((rx_byte || (rx_end && rx_eom)) && rdir_r && rcnt_r == 6'h0) ack_pend_r[rvl_r] <= 1'b1;
			if (dfin) ack_pend_r[dvl_r] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			in_wait <= 4'h0;
		end else begin
			if (rx_end && rdir_r && rx_eom) in_wait[rvl_r] <= 1'b0;
			if (dfin && beom_r[dvl_r]) in_wait[dvl_r] <= 1'b0;
			for (int i = 0; i < NVL; i++) if (in_req[i]) in_wait[i] <= 1'b1;
		end
	end

	// receive framing and per link buffer state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rst_r <= R_HDR;
			rvl_r <= 2'h0;
			rcnt_r <= 6'h0;
			rdir_r <= 1'b0;
			bfull_r <= 4'h0;
			beom_r <= 4'h0;
			for (int i = 0; i < NVL; i++) blen_r[i] <= 6'h0;
		end else begin
			if (rx_hdr) begin
				rvl_r <= prx_bits[1:0];
				rcnt_r <= 6'h0;
				rdir_r <= in_wait[prx_bits[1:0]];
				rst_r <= R_BODY;
			end
			if (rx_byte && rcnt_r != PKT_MAX) rcnt_r <= rcnt_r + 6'h1;
			if (rx_end) begin
				rst_r <= R_HDR;
				if (!rdir_r && !got_ack) begin
					bfull_r[rvl_r] <= 1'b1;
					beom_r[rvl_r] <= rx_eom;
					blen_r[rvl_r] <= rcnt_r;
				end
			end
			if (dfin) bfull_r[dvl_r] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rx_byte && !rdir_r && rcnt_r != PKT_MAX) bmem[{rvl_r, rcnt_r[4:0]}] <= prx_bits;
	end

	// hands a buffered packet over once the process asks
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dact_r <= 1'b0;
			dvl_r <= 2'h0;
			didx_r <= 6'h0;
		end else if (!dact_r) begin
			if (dpick[2]) begin
				dact_r <= 1'b1;
				dvl_r <= dpick[1:0];
				didx_r <= 6'h0;
			end
		end else if (dgo) begin
			if (dfin) dact_r <= 1'b0;
			else didx_r <= didx_r + 6'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rcv_valid <= 1'b0;
			rcv_chan <= 2'h0;
			rcv_byte <= 8'h0;
			in_done <= 1'b0;
			in_done_chan <= 2'h0;
			link_perr <= 1'b0;
		end else begin
			rcv_valid <= (rx_byte && rdir_r) || (dgo && !dfin);
			rcv_chan <= rx_byte ? rvl_r : dvl_r;
			rcv_byte <= rx_byte ? prx_bits : bmem[{dvl_r, didx_r[4:0]}];
			in_done <= (rx_end && rdir_r && rx_eom) || (dfin && beom_r[dvl_r]);
			in_done_chan <= rx_end ? rvl_r : dvl_r;
			link_perr <= prx_valid && prx_perr;
		end
	end
endmodule // vcl_dev_end
`default_nettype wire

/* vcl_peer_end.sv */
/*
 vcl_peer_end: the far end, one message in flight, always ready to input.
 assumes vcl_ds_phy from the device end file and a byte source with take.
*/
`timescale 1ns/10ps
`default_nettype none
module vcl_peer_end import vcl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link
	vcl_link_if.peer link,
	// message start
	input wire logic pm_valid,
	input wire logic [1:0] pm_chan,
	output logic pm_ready,
	// byte source
	input wire logic pb_valid,
	input wire logic [7:0] pb_data,
	input wire logic pb_last,
	output logic pb_take,
	// received bytes
	output logic pr_valid,
	output logic [1:0] pr_chan,
	output logic [7:0] pr_byte,
	output logic pr_end,
	output logic pr_perr
);
	vcl_tx_t tst_r;
	vcl_rx_t rst_r;
	logic [3:0] ack_pend_r;
	logic [1:0] mvl_r, tvl_r, rvl_r;
	logic [5:0] tcnt_r, rcnt_r;
	logic busy_r, wack_r, fin_r, tack_r, teom_r;
	logic ptx_valid, ptx_ctl, ptx_ready, tload, prx_valid, prx_ctl, prx_perr;
	logic rx_byte, rx_end, rx_eom, got_ack;
	logic [7:0] ptx_bits, prx_bits;
	logic [2:0] apick;

	vcl_ds_phy u_phy (
		.clk(clk),
		.sys_rst(sys_rst),
		.tx_valid(ptx_valid),
		.tx_ctl(ptx_ctl),
		.tx_bits(ptx_bits),
		.tx_ready(ptx_ready),
		.rx_valid(prx_valid),
		.rx_ctl(prx_ctl),
		.rx_bits(prx_bits),
		.rx_perr(prx_perr),
		.d_out(link.peer_data),
		.s_out(link.peer_strobe),
		.d_in(link.dev_data),
		.s_in(link.dev_strobe)
	);

	assign rx_byte = prx_valid && !prx_ctl && rst_r == R_BODY;
	assign rx_end = prx_valid && prx_ctl && rst_r == R_BODY;
	assign rx_eom = prx_bits[1:0] == CTL_EOM;
	assign got_ack = rx_end && !rx_eom && rcnt_r == 6'h0;
	assign apick = rr_pick(ack_pend_r, RR_RST);
	assign tload = ptx_valid && ptx_ready;

	always_comb begin
		ptx_valid = 1'b0;
		ptx_ctl = 1'b0;
		ptx_bits = 8'h0;
		case (tst_r)
			T_HDR: begin
				ptx_valid = 1'b1;
				ptx_bits = {6'h0, tvl_r};
			end
			T_BODY: begin
				ptx_valid = pb_valid;
				ptx_bits = pb_data;
			end
			T_END: begin
				ptx_valid = 1'b1;
				ptx_ctl = 1'b1;
				ptx_bits = {6'h0, teom_r ? CTL_EOM : CTL_EOP};
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tst_r <= T_IDLE;
			tvl_r <= 2'h0;
			tack_r <= 1'b0;
			teom_r <= 1'b0;
			tcnt_r <= 6'h0;
		end else begin
			case (tst_r)
				T_IDLE: if (apick[2]) begin
					tvl_r <= apick[1:0];
					tack_r <= 1'b1;
					tst_r <= T_HDR;
				end else if (busy_r && !wack_r && !fin_r && pb_valid) begin
					tvl_r <= mvl_r;
					tack_r <= 1'b0;
					tst_r <= T_HDR;
				end
				T_HDR: if (tload) begin
					tst_r <= tack_r ? T_END : T_BODY;
					tcnt_r <= 6'h0;
					teom_r <= 1'b0;
				end
				T_BODY: if (tload) begin
					tcnt_r <= tcnt_r + 6'h1;
					if (pb_last) begin
						teom_r <= 1'b1;
						tst_r <= T_END;
					end else if (tcnt_r == PKT_MAX - 6'h1) begin
						tst_r <= T_END;
					end
				end
				T_END: if (tload) tst_r <= T_IDLE;
				default: tst_r <= T_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) pb_take <= 1'b0;
		else pb_take <= tst_r == T_BODY && tload;
	end

	// message in flight; each packet waits for its ack
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
			pm_ready <= 1'b0;
			mvl_r <= 2'h0;
			wack_r <= 1'b0;
			fin_r <= 1'b0;
		end else begin
			if (!busy_r) pm_ready <= 1'b1;
			if (pm_valid && pm_ready) begin
				busy_r <= 1'b1;
				pm_ready <= 1'b0;
				mvl_r <= pm_chan;
			end
			if (tst_r == T_HDR && tload && !tack_r) wack_r <= 1'b1;
			if (tst_r == T_END && tload && teom_r) fin_r <= 1'b1;
			if (got_ack && rvl_r == mvl_r) wack_r <= 1'b0;
			if (busy_r && fin_r && !wack_r) begin
				busy_r <= 1'b0;
				fin_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_pend_r <= 4'h0;
		end else begin
			if (tst_r == T_IDLE && apick[2]) ack_pend_r[apick[1:0]] <= 1'b0;
			if ((rx_byte || (rx_end && rx_eom)) && rcnt_r == 6'h0) ack_pend_r[rvl_r] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rst_r <= R_HDR;
			rvl_r <= 2'h0;
			rcnt_r <= 6'h0;
		end else begin
			if (prx_valid && !prx_ctl && rst_r == R_HDR) begin
				rvl_r <= prx_bits[1:0];
				rcnt_r <= 6'h0;
				rst_r <= R_BODY;
			end
			if (rx_byte && rcnt_r != PKT_MAX) rcnt_r <= rcnt_r + 6'h1;
			if (rx_end) rst_r <= R_HDR;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pr_valid <= 1'b0;
			pr_chan <= 2'h0;
			pr_byte <= 8'h0;
			pr_end <= 1'b0;
			pr_perr <= 1'b0;
		end else begin
			pr_valid <= rx_byte;
			pr_chan <= rvl_r;
			pr_byte <= prx_bits;
			pr_end <= rx_end && rx_eom;
			pr_perr <= prx_valid && prx_perr;
		end
	end
endmodule // vcl_peer_end
`default_nettype wire

/* vcl_link_props.sv */
/*
 vcl_link_props: concurrent checks on both directions of the four wire serial link.
 assumes one clk for both ends and sys_rst synchronous, active high.
*/
`timescale 1ns/10ps
`default_nettype none
module vcl_link_props import vcl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// device to peer lines
	input wire logic dev_data,
	input wire logic dev_strobe,
	// peer to device lines
	input wire logic peer_data,
	input wire logic peer_strobe
);
	logic [1:0] ln_d, ln_s, prv_d_r, prv_s_r, par_r, ctl_r, tok_end_r;
	logic [3:0] cnt_r [2];
	assign ln_d = {peer_data, dev_data};
	assign ln_s = {peer_strobe, dev_strobe};

	// previous line levels, to spot each bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prv_d_r <= 2'h0;
			prv_s_r <= 2'h0;
		end else begin
			prv_d_r <= ln_d;
			prv_s_r <= ln_s;
		end
	end

	// deframer per direction: bit count, flag and running parity
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			par_r <= 2'h0;
			ctl_r <= 2'h0;
			tok_end_r <= 2'h0;
			cnt_r[0] <= 4'h0;
			cnt_r[1] <= 4'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				tok_end_r[i] <= 1'b0;
				if ((ln_d[i] ^ ln_s[i]) != (prv_d_r[i] ^ prv_s_r[i])) begin
					par_r[i] <= (cnt_r[i] == 4'h0) ? ln_d[i] : par_r[i] ^ ln_d[i];
					if (cnt_r[i] == 4'h1) ctl_r[i] <= ln_d[i];
					if (cnt_r[i] >= 4'h3 && cnt_r[i] + 4'h1 == (ctl_r[i] ? CTL_LEN : DATA_LEN)) begin
						tok_end_r[i] <= 1'b1;
						cnt_r[i] <= 4'h0;
					end else begin
						cnt_r[i] <= cnt_r[i] + 4'h1;
					end
				end
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_dev_one_edge: assert property (!($changed(dev_data) && $changed(dev_strobe)))
		else $error("device data and strobe moved together");
	a_peer_one_edge: assert property (!($changed(peer_data) && $changed(peer_strobe)))
		else $error("peer data and strobe moved together");
	a_dev_bit_period: assert property ($changed(dev_data ^ dev_strobe) |=> ($stable(dev_data) && $stable(dev_strobe)) [*7])
		else $error("device bit shorter than eight clocks");
	a_peer_bit_period: assert property ($changed(peer_data ^ peer_strobe) |=> ($stable(peer_data) && $stable(peer_strobe)) [*7])
		else $error("peer bit shorter than eight clocks");
	a_dev_rst_quiet: assert property ($fell(sys_rst) |-> (!dev_data && !dev_strobe) [*2])
		else $error("device lines not low after reset");
	a_peer_rst_quiet: assert property ($fell(sys_rst) |-> (!peer_data && !peer_strobe) [*2])
		else $error("peer lines not low after reset");
	a_dev_tok_parity: assert property (tok_end_r[0] |-> par_r[0])
		else $error("device token parity not odd");
	a_peer_tok_parity: assert property (tok_end_r[1] |-> par_r[1])
		else $error("peer token parity not odd");
endmodule // vcl_link_props
`default_nettype wire

/* tb_virtual_channel_link_flow_control.sv */
/*
 tb_virtual_channel_link_flow_control: device end and peer end joined by the link.
 assumes clk of 100 ns, sys_rst synchronous active high, inputs driven on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_virtual_channel_link_flow_control;
	logic clk, sys_rst, snd_valid, snd_ready, out_done, rcv_valid, in_done, link_perr;
	logic pm_valid, pm_ready, pb_valid, pb_last, pb_take, pr_valid, pr_end, pr_perr, run;
	logic [3:0] src_valid, src_last, src_take, out_wait, in_req, in_wait;
	logic [2:0] snd_chan, out_done_chan;
	logic [1:0] rcv_chan, in_done_chan, pm_chan, pr_chan;
	logic [7:0] rcv_byte, pb_data, pr_byte, done_m, in_m, end_m;
	logic [31:0] src_data;
	int mismatches, n_compared, seed, n, v, k;
	logic [7:0] src_q [4][$];
	logic [7:0] exp_p [4][$];
	logic [7:0] exp_d [4][$];
	logic [7:0] pb_q [$];
	int mlen [4][$];

	vcl_link_if u_vcl_link_if ();
	vcl_dev_end u_vcl_dev_end (.clk(clk), .sys_rst(sys_rst), .link(u_vcl_link_if), .snd_valid(snd_valid),
		.snd_chan(snd_chan), .snd_ready(snd_ready), .src_valid(src_valid), .src_data(src_data),
		.src_last(src_last), .src_take(src_take), .out_wait(out_wait), .out_done(out_done),
		.out_done_chan(out_done_chan), .in_req(in_req), .in_wait(in_wait), .rcv_valid(rcv_valid),
		.rcv_chan(rcv_chan), .rcv_byte(rcv_byte), .in_done(in_done), .in_done_chan(in_done_chan),
		.link_perr(link_perr));
	vcl_peer_end u_vcl_peer_end (.clk(clk), .sys_rst(sys_rst), .link(u_vcl_link_if), .pm_valid(pm_valid),
		.pm_chan(pm_chan), .pm_ready(pm_ready), .pb_valid(pb_valid), .pb_data(pb_data), .pb_last(pb_last),
		.pb_take(pb_take), .pr_valid(pr_valid), .pr_chan(pr_chan), .pr_byte(pr_byte), .pr_end(pr_end),
		.pr_perr(pr_perr));
	vcl_link_props u_vcl_link_props (.clk(clk), .sys_rst(sys_rst), .dev_data(u_vcl_link_if.dev_data),
		.dev_strobe(u_vcl_link_if.dev_strobe), .peer_data(u_vcl_link_if.peer_data),
		.peer_strobe(u_vcl_link_if.peer_strobe));

	always #50 clk = ~clk;

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s: %h/%h", $time, what, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp, input string what);
		chk_byte({7'h0, got}, {7'h0, exp}, what);
	endtask

	function automatic logic [7:0] pop_exp(input logic dir, input logic [1:0] c);
		if (dir && exp_d[c].size() != 0) return exp_d[c].pop_front();
		if (!dir && exp_p[c].size() != 0) return exp_p[c].pop_front();
		return 8'hxx;
	endfunction

	// dir 0: device sends on link c, dir 1: peer sends
	task automatic fill(input logic dir, input int c, input int len);
		logic [7:0] b;
		for (int i = 0; i < len; i++) begin
			b = 8'($random(seed));
			if (dir) begin
				pb_q.push_back(b);
				exp_d[c].push_back(b);
			end else begin
				src_q[c].push_back(b);
				exp_p[c].push_back(b);
			end
		end
		if (!dir) mlen[c].push_back(len);
	endtask

	task automatic send_req(input logic [2:0] c);
		snd_chan = c;
		snd_valid = 1'b1;
		for (int i = 0; i < 9000 && snd_ready !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		snd_valid = 1'b0;
		@(negedge clk);
	endtask

	task automatic peer_req(input logic [1:0] c);
		pm_chan = c;
		pm_valid = 1'b1;
		for (int i = 0; i < 9000 && pm_ready !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		pm_valid = 1'b0;
	endtask

	task automatic ask_in(input int c);
		in_req[c] = 1'b1;
		@(negedge clk);
		in_req[c] = 1'b0;
		@(negedge clk);
	endtask

	// sel 0: sender done, 1: input done, 2: peer end of message
	task automatic wait_bit(input int sel, input int b, input int lim);
		logic [7:0] m;
		for (int i = 0; i <= lim; i++) begin
			m = sel == 0 ? done_m : sel == 1 ? in_m : end_m;
			if (m[b] === 1'b1 || i == lim) break;
			@(negedge clk);
		end
		chk_flag(m[b], 1'b1, "completion");
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// byte sources and receive monitors
	always @(negedge clk) begin
		for (int c = 0; c < 4; c++) begin
			if (src_take[c] === 1'b1 && src_q[c].size() != 0) begin
				void'(src_q[c].pop_front());
				mlen[c][0]--;
				if (mlen[c][0] == 0) void'(mlen[c].pop_front());
			end
			src_valid[c] = src_q[c].size() != 0;
			src_data[8*c+:8] = src_valid[c] ? src_q[c][0] : 8'h0;
			src_last[c] = mlen[c].size() != 0 && mlen[c][0] == 1;
		end
		if (pb_take === 1'b1 && pb_q.size() != 0) void'(pb_q.pop_front());
		pb_valid = pb_q.size() != 0;
		pb_data = pb_valid ? pb_q[0] : 8'h0;
		pb_last = pb_q.size() == 1;
		if (run) begin
			if (pr_valid === 1'b1) chk_byte(pr_byte, pop_exp(1'b0, pr_chan), "peer rx");
			if (rcv_valid === 1'b1) chk_byte(rcv_byte, pop_exp(1'b1, rcv_chan), "dev rx");
			if ((link_perr | pr_perr) !== 1'b0) chk_flag(link_perr | pr_perr, 1'b0, "parity");
			if (in_done === 1'b1) chk_flag(exp_d[in_done_chan].size() == 0, 1'b1, "dev end");
			if (in_done === 1'b1) in_m[in_done_chan] = 1'b1;
			if (pr_end === 1'b1) end_m[pr_chan] = 1'b1;
			if (out_done === 1'b1) done_m[out_done_chan] = 1'b1;
		end
	end

	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		$display("MISMATCH %0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{snd_valid, pm_valid, pb_valid, pb_last, run, snd_chan, pm_chan} = 10'h0;
		{in_req, src_valid, src_last, src_data, pb_data} = 52'h0;
		{done_m, in_m, end_m} = 24'h0;
		mismatches = 0;
		n_compared = 0;
		seed = 32'h5095f135;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		run = 1'b1;
		chk_flag(snd_ready & pm_ready, 1'b1, "ready after reset");
		chk_byte({out_wait, in_wait}, 8'h0, "waits after reset");
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			done_m = 8'h0;
			send_req({1'b1, 2'(c)});
			wait_bit(0, 4 + c, 12);
		end
		chk_byte({out_wait, 2'h0, u_vcl_link_if.dev_data, u_vcl_link_if.dev_strobe}, 8'h0, "soft idle");
		$display("test soft channels done");
		for (int i = 0; i < 6; i++) begin
			n = i == 0 ? 1 : i == 1 ? 32 : i == 2 ? 33 : 1 + int'($unsigned($random(seed)) % 40);
			v = int'($unsigned($random(seed)) % 4);
			{done_m, end_m} = 16'h0;
			fill(1'b0, v, n);
			send_req({1'b0, 2'(v)});
			repeat (2) @(negedge clk);
			chk_flag(out_wait[v], 1'b1, "sender waits");
			wait_bit(0, v, 6000);
			chk_flag(out_wait[v] | ((n - 1) % 32 >= 7 && end_m[v]), 1'b0, "early ack");
			wait_bit(2, v, 4000);
		end
		$display("test device send done");
		for (int i = 1; i < 3; i++) begin
			in_m = 8'h0;
			ask_in(i);
			chk_flag(in_wait[i], 1'b1, "input waits");
			fill(1'b1, i, i == 1 ? 33 : 1 + int'($unsigned($random(seed)) % 32));
			peer_req(2'(i));
			wait_bit(1, i, 6000);
			chk_flag(in_wait[i], 1'b0, "input released");
		end
		in_m = 8'h0;
		fill(1'b1, 3, 5);
		peer_req(2'h3);
		for (k = 0; k < 3000 && pb_q.size() != 0; k++) @(negedge clk);
		repeat (300) @(negedge clk);
		chk_flag(in_m[3] | pm_ready, 1'b0, "unsolicited not acked");
		chk_byte(8'(exp_d[3].size()), 8'h5, "buffered");
		ask_in(3);
		wait_bit(1, 3, 600);
		$display("test device receive done");
		{done_m, in_m} = 16'h0;
		fill(1'b0, 0, 33);
		fill(1'b0, 1, 3);
		ask_in(2);
		fill(1'b1, 2, 20);
		send_req(3'h0);
		send_req(3'h1);
		peer_req(2'h2);
		wait_bit(0, 1, 6000);
		chk_flag(done_m[0], 1'b0, "short message first");
		wait_bit(0, 0, 8000);
		wait_bit(1, 2, 6000);
		$display("test interleave done");
		done_m = 8'h0;
		fill(1'b0, 0, 20);
		fill(1'b0, 0, 2);
		send_req(3'h0);
		send_req(3'h0);
		snd_chan = 3'h5;
		snd_valid = 1'b1;
		for (k = 0; k < 12 && snd_ready === 1'b1; k++) @(negedge clk);
		snd_valid = 1'b0;
		chk_flag(snd_ready === 1'b0 && k >= 6 && k <= 8, 1'b1, "queue refuses");
		wait_bit(0, 5, 6000);
		{done_m, end_m} = 16'h0;
		wait_bit(0, 0, 2000);
		wait_bit(2, 0, 2000);
		chk_flag(snd_ready, 1'b1, "queue drained");
		for (int c = 0; c < 4; c++) chk_flag(exp_p[c].size() + exp_d[c].size() == 0, 1'b1, "leftover");
		$display("test send queue done");
		finish_test();
	end
endmodule // tb_virtual_channel_link_flow_control
`default_nettype wire
